//--- lcoq_cfg.svh
`ifndef LCOQ_CFG_SVH
`define LCOQ_CFG_SVH
//==============================================================================
// Constants for the link channel ordering and priority scheduler
//==============================================================================
// What this block does
// - Posted requests pass stalled nonposted requests
// - Responses pass stalled nonposted requests
// - Posted requests pass blocked responses
// - High-priority mode gives two service classes
// - Separate high-priority posted, nonposted, response buffers
// - Class-bit reads and writes enter high-priority channels
// - Class-bit responses enter high-priority response channel
// - Buffer-release class bit selects high-priority credits
// - Broadcast and atomic never use high-priority channels
// - Fence and flush go high-priority only when class 1
// - Cold reset disables mode; warm reset applies enable
// - No ordering or fairness across the two classes
// - Same ordering inside high-priority as normal channels
// - Strict priority: high class always served first
// - Mode enable is per link
// - Flagged responses may pass stalled posted requests
// - Normal mode: no high channels, release class 0
// - Normal mode: commands may carry either class value
// - Normal mode: class bit forwarded; a response also takes on its request's class
// - Nonposted with class set gives response with class

//==============================================================================
// Register map (byte offsets on the APB bus)
//==============================================================================
`define LCOQ_CTRL_OFF      12'h000
`define LCOQ_STAT_OFF      12'h004
`define LCOQ_CTRL_HPEN_BIT 0
`define LCOQ_CTRL_RST      1'h0
`define LCOQ_STAT_HPACT    0
`define LCOQ_STAT_NE_LSB   8
`define LCOQ_STAT_OV_BIT   16

//==============================================================================
// Channel numbering: normal class 0..2, high-priority class 3..5
//==============================================================================
`define LCOQ_CH_PW   2'h0
`define LCOQ_CH_NP   2'h1
`define LCOQ_CH_RSP  2'h2
`define LCOQ_HP_BASE 3'h3
`define LCOQ_NCH     6
`define LCOQ_CRD_FW  2

`endif

//--- lcoq_pkg.sv
//==============================================================================
// Types shared by the scheduler
//==============================================================================
package lcoq_pkg;

   // Packet kinds seen on the link
   typedef enum logic [3:0] {
      CMD_POSTED_WR,
      CMD_NP_WR,
      CMD_READ,
      CMD_READ_RESPONSE,
      CMD_TARGET_DONE_RESPONSE,
      CMD_BROADCAST,
      CMD_ATOMIC,
      CMD_FENCE,
      CMD_FLUSH,
      CMD_BUFFER_RELEASE_PACKET
   } lcoq_cmd_type;

   // One packet; payload[5:0] of a buffer release holds 2-bit credits
   typedef struct packed {
      lcoq_cmd_type cmd;
      logic         cls;
      logic         pass_posted_writes_flag;
      logic [4:0]   tag;
      logic [31:0]  payload;
   } lcoq_pkt_type;

   // Queue entry: packet plus arrival stamp used for age ordering
   typedef struct packed {
      lcoq_pkt_type pkt;
      logic [7:0]   stamp;
   } lcoq_entry_type;

   // Credit return for one freed buffer entry
   typedef struct packed {
      logic       valid;
      logic       cls;
      logic [1:0] chan;
   } lcoq_rel_type;

endpackage

//--- lcoq_link_sched.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "lcoq_cfg.svh"

module lcoq_link_sched
   import lcoq_pkg::*;
#(
   parameter int DEPTH = 4,   // Entries per virtual channel buffer
   parameter int CRW   = 4    // Width of each transmit credit counter
) (
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output logic      [31:0]    prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire logic           link_warm_reset,
   input  wire logic           in_valid,
   input  wire lcoq_pkt_type   in_pkt,
   output logic                in_ready,
   output logic                out_valid,
   output lcoq_pkt_type        out_pkt,
   output logic                out_hp,
   input  wire logic           out_ready,
   output lcoq_rel_type        rel_out,
   output logic                hp_active
);

   //===========================================================================
   // Elaboration checks
   //===========================================================================
   // Age compare on 8-bit stamps needs fewer than 128 entries in flight
   if (DEPTH < 2 || DEPTH > 16) begin : g_bad_depth
      $error("DEPTH must lie between 2 and 16");
   end
   if (CRW < 2 || CRW > 8) begin : g_bad_crw
      $error("CRW must lie between 2 and 8");
   end

   localparam int CW = $clog2(DEPTH + 1);   // Occupancy counter width
   localparam int PW = $clog2(DEPTH);       // Pointer width

   //===========================================================================
   // Helper functions
   //===========================================================================
   // Stamp a is older than stamp b (modular compare)
   function automatic logic older(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      return d[7];
   endfunction

   // Oldest eligible of three channel heads
   function automatic logic [1:0] pick3(input logic [2:0] ok,
                                        input logic [2:0][7:0] s);
      logic [1:0] p;
      logic       f;
      p = 2'h0;
      f = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (ok[i] && (!f || older(s[i], s[p]))) begin
            p = i[1:0];
            f = 1'b1;
         end
      end
      return p;
   endfunction

   //===========================================================================
   // State
   //===========================================================================
   logic                 hp_en_q;      // Software enable, this link only
   logic                 hp_active_q;  // Mode latched at warm reset
   logic [7:0]           stamp_q;      // Arrival stamp counter
   logic [31:0]          cls_tab_q;    // Class bit per nonposted tag
   logic                 in_ready_q;
   logic                 out_valid_q;
   lcoq_pkt_type         out_pkt_q;
   logic                 out_hp_q;
   lcoq_rel_type         rel_q;
   logic                 pready_q;
   logic [31:0]          prdata_q;
   logic                 pslverr_q;

   //===========================================================================
   // Ingress classification
   //===========================================================================
   wire lcoq_cmd_type cmd      = in_pkt.cmd;
   wire logic is_bufrel   = (cmd == CMD_BUFFER_RELEASE_PACKET);
   wire logic is_resp     = (cmd == CMD_READ_RESPONSE) ||
                            (cmd == CMD_TARGET_DONE_RESPONSE);
   wire logic is_np       = (cmd == CMD_NP_WR) || (cmd == CMD_READ) ||
                            (cmd == CMD_ATOMIC) || (cmd == CMD_FLUSH);
   wire logic is_pw       = (cmd == CMD_POSTED_WR) ||
                            (cmd == CMD_BROADCAST) || (cmd == CMD_FENCE);
   // Broadcast and atomic are never candidates for the high class
   wire logic hp_kind     = !(cmd == CMD_BROADCAST) &&
                            !(cmd == CMD_ATOMIC) && !is_bufrel;
   // A response echoes the class of the request that it answers
   wire logic cls_eff     = in_pkt.cls |
                            (is_resp & cls_tab_q[in_pkt.tag]);
   // Fence and flush count here only when class equals 1
   wire logic in_hp       = hp_active_q & cls_eff & hp_kind;
   wire logic [1:0] base  = is_pw   ? `LCOQ_CH_PW  :
                            is_resp ? `LCOQ_CH_RSP : `LCOQ_CH_NP;
   wire logic [2:0] in_ch = in_hp ? (`LCOQ_HP_BASE + {1'b0, base})
                                  : {1'b0, base};
   wire logic accept      = in_valid & in_ready_q & !link_warm_reset;
   wire logic rel_acc     = accept & is_bufrel;
   // In normal mode the release class is ignored; only class 0 exists
   wire logic rel_hp      = hp_active_q & in_pkt.cls;

   // Class bit is kept as computed so far-away devices can use it
   lcoq_pkt_type   in_fwd;
   lcoq_entry_type in_ent;
   always_comb begin
      in_fwd     = in_pkt;
      in_fwd.cls = cls_eff;
      in_ent     = '{pkt: in_fwd, stamp: stamp_q};
   end

   //===========================================================================
   // Per-channel buffers and transmit credits
   //===========================================================================
   logic [5:0]      push;
   logic [5:0]      pop;
   logic [5:0]      ne;         // Channel holds a packet
   logic [5:0]      crd_ok;     // Partner has room in that channel
   logic [5:0]      room;       // Room for one more next cycle
   logic [5:0][7:0] hst;        // Head stamps
   logic [5:0]      hppw;       // Head pass-posted-writes flag
   lcoq_pkt_type    head [`LCOQ_NCH];

   for (genvar c = 0; c < `LCOQ_NCH; c++) begin : g_ch
      localparam int   CI    = c % 3;
      localparam logic IS_HP = (c >= 3);

      lcoq_entry_type  mem_q [DEPTH];   // Flow-control buffer
      logic [CW-1:0]   cnt_q;
      logic [PW-1:0]   wp_q;
      logic [PW-1:0]   rp_q;
      logic [CRW-1:0]  crd_q;

      wire logic [CW-1:0] cnt_d = CW'(cnt_q + CW'(push[c]) - CW'(pop[c]));
      wire logic [PW-1:0] wp_nx = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      wire logic [PW-1:0] rp_nx = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      wire logic [1:0]    add   = (rel_acc && (rel_hp == IS_HP)) ?
                                  in_pkt.payload[2*CI +: 2] : 2'h0;
      wire logic [CRW+1:0] sum  = {2'h0, crd_q} + (CRW + 2)'(add) -
                                  (CRW + 2)'(pop[c]);
      wire logic [CRW-1:0] crd_d = (sum > {2'h0, {CRW{1'b1}}}) ?
                                   {CRW{1'b1}} : sum[CRW-1:0];

      assign push[c] = accept & !is_bufrel & (in_ch == 3'(c));
      assign ne[c]   = (cnt_q != '0);
      assign crd_ok[c] = (crd_q != '0);
      assign room[c] = (cnt_d < CW'(DEPTH));
      assign head[c] = mem_q[rp_q].pkt;
      assign hst[c]  = mem_q[rp_q].stamp;
      assign hppw[c] = mem_q[rp_q].pkt.pass_posted_writes_flag;

      // Occupancy, pointers and credits; warm reset empties the channel
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt_q <= '0;
            wp_q  <= '0;
            rp_q  <= '0;
            crd_q <= '0;
         end else if (link_warm_reset) begin
            cnt_q <= '0;
            wp_q  <= '0;
            rp_q  <= '0;
            crd_q <= '0;
         end else begin
            cnt_q <= cnt_d;
            crd_q <= crd_d;
            if (push[c]) begin
               wp_q <= wp_nx;
            end
            if (pop[c]) begin
               rp_q <= rp_nx;
            end
         end
      end

      // Storage needs no reset; occupancy says what is valid
      always_ff @(posedge pclk) begin
         if (push[c]) begin
            mem_q[wp_q] <= in_ent;
         end
      end
   end

   //===========================================================================
   // Ordering within each class
   //===========================================================================
   // The same eligibility test serves both classes, and nothing compares
   // stamps across classes, so the classes never order against each other
   logic [1:0]      any_k;
   logic [1:0][1:0] sel_k;

   for (genvar k = 0; k < 2; k++) begin : g_cls
      localparam int B = 3 * k;
      // Posted goes whenever it has credit: passes both stalled kinds
      wire logic pw_ok = ne[B] & crd_ok[B];
      // Nonposted may not pass an older posted request
      wire logic np_ok = ne[B+1] & crd_ok[B+1] &
                         !(ne[B] && older(hst[B], hst[B+1]));
      // Response ignores nonposted; passes posted only when flagged
      wire logic rs_ok = ne[B+2] & crd_ok[B+2] &
                         (!(ne[B] && older(hst[B], hst[B+2])) |
                          hppw[B+2]);
      wire logic [2:0] ok = {rs_ok, np_ok, pw_ok};
      assign any_k[k] = |ok;
      assign sel_k[k] = pick3(ok, {hst[B+2], hst[B+1], hst[B]});
   end

   //===========================================================================
   // Egress selection
   //===========================================================================
   // High class always wins; low class may starve, no fairness applied
   wire logic       sel_hp  = any_k[1];
   wire logic       any     = any_k[0] | any_k[1];
   wire logic [2:0] sel_ch  = sel_hp ? (`LCOQ_HP_BASE + {1'b0, sel_k[1]})
                                     : {1'b0, sel_k[0]};
   wire logic       load    = any & (!out_valid_q | out_ready) &
                              !link_warm_reset;

   for (genvar c = 0; c < `LCOQ_NCH; c++) begin : g_pop
      assign pop[c] = load & (sel_ch == 3'(c));
   end

   // Output stage holds one packet until the consumer takes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid_q <= 1'b0;
         out_pkt_q   <= '0;
         out_hp_q    <= 1'b0;
      end else if (link_warm_reset) begin
         out_valid_q <= 1'b0;
         out_hp_q    <= 1'b0;
      end else if (load) begin
         out_valid_q <= 1'b1;
         out_pkt_q   <= head[sel_ch];
         out_hp_q    <= sel_hp;
      end else if (out_ready) begin
         out_valid_q <= 1'b0;
      end
   end

   // Freed buffer entry returned to partner; class is 0 in normal mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rel_q <= '0;
      end else begin
         rel_q.valid <= load;
         rel_q.cls   <= load & sel_hp;
         rel_q.chan  <= sel_hp ? sel_k[1] : sel_k[0];
      end
   end

   //===========================================================================
   // Ingress bookkeeping
   //===========================================================================
   // Ready is registered, so it looks one push ahead and is conservative
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_ready_q <= 1'b0;
         stamp_q    <= 8'h00;
      end else begin
         in_ready_q <= !link_warm_reset & (&room);
         if (accept && !is_bufrel) begin
            stamp_q <= stamp_q + 8'h01;
         end
      end
   end

   // Remember the class of each accepted nonposted request by tag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cls_tab_q <= 32'h0000_0000;
      end else if (accept && is_np) begin
         cls_tab_q[in_pkt.tag] <= in_pkt.cls;
      end
   end

   //===========================================================================
   // Mode control
   //===========================================================================
   // Cold reset clears both; the live mode follows the enable only
   // while warm reset is held, so a change never disturbs open traffic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_active_q <= 1'b0;
      end else if (link_warm_reset) begin
         hp_active_q <= hp_en_q;
      end
   end

   //===========================================================================
   // APB slave
   //===========================================================================
   wire logic access   = psel & penable;
   wire logic done     = access & pready_q;
   wire logic hit_ctrl = (paddr == `LCOQ_CTRL_OFF);
   wire logic hit_stat = (paddr == `LCOQ_STAT_OFF);

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[`LCOQ_CTRL_HPEN_BIT] = hp_en_q;
      end else if (hit_stat) begin
         rd_mux[`LCOQ_STAT_HPACT]            = hp_active_q;
         rd_mux[`LCOQ_STAT_NE_LSB +: 6]      = ne;
         rd_mux[`LCOQ_STAT_OV_BIT]           = out_valid_q;
      end
   end

   // One wait state: answer is raised in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= access & !pready_q;
         if (access && !pready_q) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !(hit_ctrl | hit_stat);
         end else if (!access) begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // Enable takes effect at the completing edge; status is read-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_en_q <= `LCOQ_CTRL_RST;
      end else if (done && pwrite && hit_ctrl) begin
         hp_en_q <= pwdata[`LCOQ_CTRL_HPEN_BIT];
      end
   end

   //===========================================================================
   // Outputs
   //===========================================================================
   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;
   assign in_ready  = in_ready_q;
   assign out_valid = out_valid_q;
   assign out_pkt   = out_pkt_q;
   assign out_hp    = out_hp_q;
   assign rel_out   = rel_q;
   assign hp_active = hp_active_q;

endmodule

//--- lcoq_sched_checker.sv
`timescale 1ns/1ps
`include "lcoq_cfg.svh"
//============================================================
// Port checker for the link scheduler
module lcoq_sched_checker
   import lcoq_pkg::*;
(
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic [11:0]  paddr,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic         link_warm_reset,
   input wire logic         in_ready,
   input wire logic         out_valid,
   input wire lcoq_pkt_type out_pkt,
   input wire logic         out_hp,
   input wire logic         out_ready,
   input wire lcoq_rel_type rel_out,
   input wire logic         hp_active
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Only the two registers decode
   wire mapped = (paddr == `LCOQ_CTRL_OFF) || (paddr == `LCOQ_STAT_OFF);
   // Fence or flush that stays in the normal class
   wire fn_low = out_valid && !out_pkt.cls &&
      (out_pkt.cmd == CMD_FENCE || out_pkt.cmd == CMD_FLUSH);
   // Kinds that never enter the high class
   wire bc_atm = out_valid &&
      (out_pkt.cmd == CMD_BROADCAST || out_pkt.cmd == CMD_ATOMIC);
   // Channel kind a packet travels in, from its command alone
   wire [1:0] ch_exp =
      (out_pkt.cmd == CMD_READ_RESPONSE ||
       out_pkt.cmd == CMD_TARGET_DONE_RESPONSE) ? 2'h2 :
      (out_pkt.cmd == CMD_POSTED_WR || out_pkt.cmd == CMD_BROADCAST ||
       out_pkt.cmd == CMD_FENCE) ? 2'h0 : 2'h1;

   property p_err;
      pready |-> pslverr == !mapped;
   endproperty
   a_err: assert property (p_err) else $error("bad pslverr");
   // Warm reset flushes egress, so it is left out of the hold check
   property p_hold;
      out_valid && !out_ready && !link_warm_reset |=>
         out_valid && $stable(out_pkt) && $stable(out_hp);
   endproperty
   a_hold: assert property (p_hold) else $error("egress dropped");
   property p_rel;
      rel_out.valid && !$past(link_warm_reset) |->
         out_valid && rel_out.cls == out_hp && rel_out.chan == ch_exp;
   endproperty
   a_rel: assert property (p_rel) else $error("bad release");
   property p_norm;
      !hp_active |-> !(out_valid && out_hp) && !(rel_out.valid && rel_out.cls);
   endproperty
   a_norm: assert property (p_norm) else $error("high class off");
   property p_bcast;
      bc_atm |-> !out_hp;
   endproperty
   a_bcast: assert property (p_bcast) else $error("bcast high");
   property p_fence;
      fn_low |-> !out_hp;
   endproperty
   a_fence: assert property (p_fence) else $error("fence high");
   property p_frz;
      !link_warm_reset && !$past(link_warm_reset) |-> $stable(hp_active);
   endproperty
   a_frz: assert property (p_frz) else $error("mode moved");
   property p_warm;
      link_warm_reset |=> !out_valid && !in_ready;
   endproperty
   a_warm: assert property (p_warm) else $error("warm no flush");
endmodule

bind lcoq_link_sched lcoq_sched_checker u_lcoq_sched_checker (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .link_warm_reset(link_warm_reset),
   .in_ready(in_ready), .out_valid(out_valid), .out_pkt(out_pkt),
   .out_hp(out_hp), .out_ready(out_ready), .rel_out(rel_out),
   .hp_active(hp_active));

//--- lcoq_link_peer.sv
`timescale 1ns/1ps
//============================================================
// Far link partner: sink that may stall and logs what it took
module lcoq_link_peer
   import lcoq_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          stall,
   input  wire logic          out_valid,
   input  wire lcoq_pkt_type  out_pkt,
   input  wire logic          out_hp,
   output logic               out_ready,
   output lcoq_pkt_type       pkt_q [32],
   output logic [31:0]        hp_q,
   output logic [5:0]         cnt_q
);
   // Posted traffic is sunk with no dependency on other traffic
   assign out_ready = !stall;
   // Log every accepted packet; log wraps after 32 entries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 6'h0;
      end else if (out_valid && out_ready) begin
         pkt_q[cnt_q[4:0]] <= out_pkt;
         hp_q[cnt_q[4:0]]  <= out_hp;
         cnt_q             <= cnt_q + 6'h1;
      end
   end
endmodule

//--- lcoq_link_sched_tb.sv
`timescale 1ns/1ps
`include "lcoq_cfg.svh"
`define CHK(n, g, e) begin checks_done++; if ((g) !== (e)) begin \
   fail_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
//============================================================
// Bench for the link scheduler
module lcoq_link_sched_tb
   import lcoq_pkg::*;
;
   logic         pclk, pready, pslverr, in_ready, out_valid, out_hp;
   logic         presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic         pwrite = 1'b0, link_warm_reset = 1'b0, in_valid = 1'b0;
   logic         stall = 1'b0, out_ready, hp_active, err;
   logic [11:0]  paddr = 12'h0;
   logic [31:0]  pwdata = 32'h0, prdata, rd, hps;
   logic [5:0]   cnt;
   lcoq_pkt_type in_pkt = '0, out_pkt, pkts [32];
   lcoq_rel_type rel_out;
   int           fail_count, checks_done, cyc, rp;

   lcoq_link_sched u_lcoq_link_sched (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link_warm_reset(link_warm_reset),
      .in_valid(in_valid), .in_pkt(in_pkt), .in_ready(in_ready),
      .out_valid(out_valid), .out_pkt(out_pkt), .out_hp(out_hp),
      .out_ready(out_ready), .rel_out(rel_out), .hp_active(hp_active));
   lcoq_link_peer u_lcoq_link_peer (
      .pclk(pclk), .presetn(presetn), .stall(stall),
      .out_valid(out_valid), .out_pkt(out_pkt), .out_hp(out_hp),
      .out_ready(out_ready), .pkt_q(pkts), .hp_q(hps), .cnt_q(cnt));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Whole run needs about a hundred cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // One APB transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
   // Released data lines show the inverse so no stale value passes
   task automatic send(input lcoq_pkt_type p);
      in_valid <= 1'b1;
      in_pkt <= p;
      do @(posedge pclk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      in_pkt <= ~p;
      @(posedge pclk);
   endtask
   function automatic lcoq_pkt_type pk(input lcoq_cmd_type c,
      input logic cl, input logic pw, input logic [4:0] t);
      return '{c, cl, pw, t, 32'h0};
   endfunction
   task automatic credit(input logic cl, input logic [5:0] n);
      send('{CMD_BUFFER_RELEASE_PACKET, cl, 1'b0, 5'h0, {26'h0, n}});
   endtask
   // Next logged egress must match kind, tag, class and channel class
   task automatic expect_out(input lcoq_cmd_type c, input logic [4:0] t,
                             input logic cl, input logic hp);
      while (cnt <= rp) @(posedge pclk);
      `CHK("egress", {pkts[rp].cmd, pkts[rp].tag, pkts[rp].cls, hps[rp]},
           {c, t, cl, hp})
      rp++;
   endtask
   task automatic warm();
      link_warm_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      link_warm_reset <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic t_regs();
      apb(1'b0, `LCOQ_CTRL_OFF, 32'h0);
      `CHK("ctrl", {err, rd}, {1'b0, 31'h0, `LCOQ_CTRL_RST})
      apb(1'b0, `LCOQ_STAT_OFF, 32'h0);
      `CHK("stat", {err, rd}, 33'h0)
      apb(1'b1, `LCOQ_STAT_OFF, 32'h1);
      `CHK("stat_wr", {err, hp_active}, 2'b00)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("unmapped", {err, rd}, {1'b1, 32'h0})
      $display("t_regs done");
   endtask
   // Only some channels get credit, so the rest stay stalled
   task automatic t_norm();
      send(pk(CMD_READ, 1'b1, 1'b0, 5'h1));
      send(pk(CMD_TARGET_DONE_RESPONSE, 1'b0, 1'b0, 5'h3));
      send(pk(CMD_POSTED_WR, 1'b1, 1'b0, 5'h4));
      send(pk(CMD_READ_RESPONSE, 1'b0, 1'b1, 5'h1));
      credit(1'b0, 6'h01);
      expect_out(CMD_POSTED_WR, 5'h4, 1'b1, 1'b0);
      credit(1'b0, 6'h20);
      expect_out(CMD_TARGET_DONE_RESPONSE, 5'h3, 1'b0, 1'b0);
      expect_out(CMD_READ_RESPONSE, 5'h1, 1'b1, 1'b0);
      send(pk(CMD_POSTED_WR, 1'b0, 1'b0, 5'h6));
      send(pk(CMD_TARGET_DONE_RESPONSE, 1'b0, 1'b1, 5'h2));
      credit(1'b0, 6'h10);
      expect_out(CMD_TARGET_DONE_RESPONSE, 5'h2, 1'b0, 1'b0);
      credit(1'b0, 6'h01);
      expect_out(CMD_POSTED_WR, 5'h6, 1'b0, 1'b0);
      credit(1'b0, 6'h04);
      expect_out(CMD_READ, 5'h1, 1'b1, 1'b0);
      $display("t_norm done");
   endtask
   // Egress held by a stalled sink while both classes queue up
   task automatic t_hp();
      apb(1'b1, `LCOQ_CTRL_OFF, 32'h1);
      `CHK("hp_pre", hp_active, 1'b0)
      warm();
      apb(1'b0, `LCOQ_STAT_OFF, 32'h0);
      `CHK("hp_on", rd[`LCOQ_STAT_HPACT], 1'b1)
      apb(1'b1, `LCOQ_CTRL_OFF, 32'h0);
      `CHK("hp_kept", hp_active, 1'b1)
      stall <= 1'b1;
      credit(1'b0, 6'h3f);
      credit(1'b1, 6'h3f);
      send(pk(CMD_READ, 1'b0, 1'b0, 5'h5));
      send(pk(CMD_POSTED_WR, 1'b0, 1'b0, 5'h7));
      send(pk(CMD_POSTED_WR, 1'b1, 1'b0, 5'h8));
      send(pk(CMD_BROADCAST, 1'b1, 1'b0, 5'h9));
      send(pk(CMD_FENCE, 1'b1, 1'b0, 5'ha));
      send(pk(CMD_READ_RESPONSE, 1'b1, 1'b0, 5'hc));
      send(pk(CMD_FLUSH, 1'b0, 1'b0, 5'hb));
      send(pk(CMD_ATOMIC, 1'b1, 1'b0, 5'hd));
      send(pk(CMD_NP_WR, 1'b1, 1'b0, 5'he));
      stall <= 1'b0;
      expect_out(CMD_READ, 5'h5, 1'b0, 1'b0);
      expect_out(CMD_POSTED_WR, 5'h8, 1'b1, 1'b1);
      expect_out(CMD_FENCE, 5'ha, 1'b1, 1'b1);
      expect_out(CMD_READ_RESPONSE, 5'hc, 1'b1, 1'b1);
      expect_out(CMD_NP_WR, 5'he, 1'b1, 1'b1);
      expect_out(CMD_POSTED_WR, 5'h7, 1'b0, 1'b0);
      expect_out(CMD_BROADCAST, 5'h9, 1'b1, 1'b0);
      expect_out(CMD_FLUSH, 5'hb, 1'b0, 1'b0);
      expect_out(CMD_ATOMIC, 5'hd, 1'b1, 1'b0);
      warm();
      `CHK("hp_off", hp_active, 1'b0)
      $display("t_hp done");
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_norm();
      t_hp();
      final_report();
   end
endmodule
